// ---- logic/ts_sensor_top.sv ----
// Purpose: serial slave, registers and event logic of the sensor
// Assumes: I_RST is the power-on reset; I_SENSE_TEMP is the raw converter word
// Notes: sda and event are open-drain, oe_n low pulls the wire low
`include "ts_defs.svh"
module ts_sensor_top
    import ts_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `TS_TIMEOUT_CYCLES,
    parameter int CONV_CYCLES = `TS_CONV_CYCLES,
    parameter logic [15:0] MFR_ID = 16'h00a5,
    parameter logic [15:0] DEV_REV = 16'h0100
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_SCL,
    input wire logic I_SDA_I,
    input wire logic [2:0] I_ADDR_STRAP,
    input wire logic [12:0] I_SENSE_TEMP,
    output logic O_SDA_O,
    output logic O_SDA_OE_N,
    output logic O_EVENT_O,
    output logic O_EVENT_OE_N
);
    // MFR_ID and DEV_REV defaults are arbitrary values

    // ----------------------------------------
    // pin synchronisers and bus events
    // ----------------------------------------
    logic [1:0] bus_s;
    logic [1:0] bus_d;
    logic [2:0] strap_s;
    logic [12:0] temp_s;
    logic scl_s;
    logic sda_s;
    bus_evt_t evt;

    ts_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_d({I_SCL, I_SDA_I}),
        .o_q(bus_s)
    );
    ts_sync #(.W(3), .RST_VAL(3'h0)) u_strap_sync (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_d(I_ADDR_STRAP),
        .o_q(strap_s)
    );
    ts_sync #(.W(13), .RST_VAL(13'h0)) u_temp_sync (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_d(I_SENSE_TEMP),
        .o_q(temp_s)
    );

    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];
    assign evt.start = scl_s && bus_d[1] && bus_d[0] && !sda_s;
    assign evt.stop = scl_s && bus_d[1] && !bus_d[0] && sda_s;
    assign evt.rise = scl_s && !bus_d[1];
    assign evt.fall = !scl_s && bus_d[1];

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
            bus_d <= 2'h3;
        else
            bus_d <= bus_s;
    end

    // ----------------------------------------
    // clock-low timeout
    // ----------------------------------------
    logic in_txn;
    logic [31:0] to_cnt;
    logic timeout_hit;

    assign timeout_hit = in_txn && !scl_s && (to_cnt == 32'(TIMEOUT_CYCLES - 1));

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            in_txn <= 1'b0;
            to_cnt <= 32'h0;
        end
        else
        begin
            in_txn <= evt.start || (in_txn && !evt.stop && !timeout_hit);
            // only scl-low time between start and stop counts
            to_cnt <= (in_txn && !scl_s && !timeout_hit) ? to_cnt + 32'h1 : 32'h0;
        end
    end

    // ----------------------------------------
    // register view
    // ----------------------------------------
    logic [15:0] cfg_reg;
    logic [15:0] upper_alarm_limit;
    logic [15:0] lower_alarm_limit;
    logic [15:0] critical_limit;
    logic [12:0] temp_reg;
    logic event_sts;
    trip_t trip;
    logic [2:0] ptr_reg;
    logic [15:0] reg_view [8];
    logic [15:0] rd_word;

    assign trip.crit = $signed(temp_reg) > $signed(critical_limit[12:0]);
    assign trip.high = $signed(temp_reg) > $signed(upper_alarm_limit[12:0]);
    assign trip.low = $signed(temp_reg) < $signed(lower_alarm_limit[12:0]);

    assign reg_view[`TS_REG_CAP] = `TS_CAP_VALUE;
    assign reg_view[`TS_REG_CFG] = cfg_reg | (16'(event_sts) << `TS_CFG_EVT_STS);
    assign reg_view[`TS_REG_UPPER] = upper_alarm_limit;
    assign reg_view[`TS_REG_LOWER] = lower_alarm_limit;
    assign reg_view[`TS_REG_CRIT] = critical_limit;
    assign reg_view[`TS_REG_TEMP] = {trip, temp_reg};
    assign reg_view[`TS_REG_MFR] = MFR_ID;
    assign reg_view[`TS_REG_DEV] = DEV_REV;
    assign rd_word = reg_view[ptr_reg];

    // ----------------------------------------
    // serial slave state machine
    // ----------------------------------------
    state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [15:0] tx_sh;
    logic [1:0] byte_idx;
    logic rw_reg;
    logic tx_lo;
    logic nack_reg;
    logic [15:0] wdata_reg;
    logic wr_pending;
    logic sda_oe_n_reg;
    logic addr_match;
    logic [15:0] tx_next;
    logic drive_ok;

    assign addr_match = (rx_sh[7:4] == `TS_ADDR_PREAMBLE) && (rx_sh[3:1] == strap_s);
    assign tx_next = tx_lo ? rd_word : tx_sh;
    assign drive_ok = evt.fall || evt.start || evt.stop || timeout_hit;

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx_sh <= 8'h0;
            tx_sh <= 16'h0;
            byte_idx <= 2'h0;
            rw_reg <= 1'b0;
            tx_lo <= 1'b0;
            nack_reg <= 1'b1;
            wdata_reg <= 16'h0;
            wr_pending <= 1'b0;
            ptr_reg <= `TS_REG_CAP;
            sda_oe_n_reg <= 1'b1;
        end
        else if (timeout_hit)
        begin
            state <= ST_IDLE;
            sda_oe_n_reg <= 1'b1;
            wr_pending <= 1'b0;
        end
        else if (evt.start)
        begin
            // repeated start keeps the pointer just written
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            sda_oe_n_reg <= 1'b1;
            wr_pending <= 1'b0;
        end
        else if (evt.stop)
        begin
            state <= ST_IDLE;
            sda_oe_n_reg <= 1'b1;
            wr_pending <= 1'b0;
        end
        else
        begin
            case (state)
                ST_ADDR, ST_RX:
                begin
                    if (evt.rise)
                    begin
                        rx_sh <= {rx_sh[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (evt.fall && bit_cnt == 4'h8)
                    begin
                        if (state == ST_ADDR)
                        begin
                            if (addr_match)
                            begin
                                rw_reg <= rx_sh[0];
                                sda_oe_n_reg <= 1'b0;
                                state <= ST_ACK_OUT;
                            end
                            else
                                state <= ST_IDLE;
                        end
                        else
                        begin
                            sda_oe_n_reg <= 1'b0;
                            state <= ST_ACK_OUT;
                            if (byte_idx != 2'h3)
                                byte_idx <= byte_idx + 2'h1;
                            case (byte_idx)
                                2'h0: ptr_reg <= rx_sh[2:0];
                                2'h1: wdata_reg[15:8] <= rx_sh;
                                2'h2:
                                begin
                                    wdata_reg[7:0] <= rx_sh;
                                    wr_pending <= 1'b1;
                                end
                                default: wr_pending <= wr_pending;
                            endcase
                        end
                    end
                end
                ST_ACK_OUT:
                begin
                    if (evt.fall)
                    begin
                        if (rw_reg)
                        begin
                            sda_oe_n_reg <= rd_word[15];
                            tx_sh <= {rd_word[14:0], 1'b0};
                            bit_cnt <= 4'h1;
                            tx_lo <= 1'b0;
                            state <= ST_TX;
                        end
                        else
                        begin
                            sda_oe_n_reg <= 1'b1;
                            bit_cnt <= 4'h0;
                            state <= ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (evt.fall)
                    begin
                        if (bit_cnt == 4'h8)
                        begin
                            sda_oe_n_reg <= 1'b1;
                            state <= ST_ACK_IN;
                        end
                        else
                        begin
                            sda_oe_n_reg <= tx_sh[15];
                            tx_sh <= {tx_sh[14:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_ACK_IN:
                begin
                    if (evt.rise)
                        nack_reg <= sda_s;
                    else if (evt.fall)
                    begin
                        if (nack_reg)
                            state <= ST_IDLE;
                        else
                        begin
                            sda_oe_n_reg <= tx_next[15];
                            tx_sh <= {tx_next[14:0], 1'b0};
                            bit_cnt <= 4'h1;
                            tx_lo <= !tx_lo;
                            state <= ST_TX;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // register writes, applied at stop
    // ----------------------------------------
    logic wr_go;
    logic wr_cfg;
    logic wr_alarm;
    logic wr_crit;
    logic clear_pulse;
    logic [15:0] cfg_next;
    logic [15:0] lim_next;

    assign wr_go = evt.stop && wr_pending;
    assign wr_cfg = wr_go && (ptr_reg == `TS_REG_CFG);
    // lock bits only fall at power-on
    assign wr_alarm = wr_go && !cfg_reg[`TS_CFG_ALARM_LOCK] &&
        (ptr_reg == `TS_REG_UPPER || ptr_reg == `TS_REG_LOWER);
    assign wr_crit = wr_go && !cfg_reg[`TS_CFG_CRIT_LOCK] && (ptr_reg == `TS_REG_CRIT);
    assign clear_pulse = wr_cfg && wdata_reg[`TS_CFG_CLEAR];
    assign cfg_next = (wdata_reg & `TS_CFG_WMASK) | (cfg_reg & `TS_CFG_LOCKS);
    assign lim_next = wdata_reg & `TS_LIM_WMASK;

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            cfg_reg <= `TS_RW_RESET;
            upper_alarm_limit <= `TS_RW_RESET;
            lower_alarm_limit <= `TS_RW_RESET;
            critical_limit <= `TS_RW_RESET;
        end
        else
        begin
            if (wr_cfg)
                cfg_reg <= cfg_next;
            if (wr_alarm && ptr_reg == `TS_REG_UPPER)
                upper_alarm_limit <= lim_next;
            if (wr_alarm && ptr_reg == `TS_REG_LOWER)
                lower_alarm_limit <= lim_next;
            if (wr_crit)
                critical_limit <= lim_next;
        end
    end

    // ----------------------------------------
    // conversion and event output
    // ----------------------------------------
    logic shdn;
    logic sample_pulse;
    logic cond;
    logic cond_prev;
    logic evt_on;
    logic ev_level;

    assign shdn = cfg_reg[`TS_CFG_SHDN];
    assign cond = cfg_reg[`TS_CFG_CRIT_ONLY] ? trip.crit : (trip.crit || trip.high || trip.low);
    assign evt_on = cfg_reg[`TS_CFG_EVT_EN] && event_sts;
    assign ev_level = cfg_reg[`TS_CFG_EVT_POL] ? evt_on : !evt_on;

    ts_conv_timer #(.CONV_CYCLES(CONV_CYCLES)) u_conv (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_run(!shdn),
        .o_sample(sample_pulse)
    );

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            temp_reg <= 13'h0;
            cond_prev <= 1'b0;
            event_sts <= 1'b0;
            O_SDA_O <= 1'b0;
            O_SDA_OE_N <= 1'b1;
            O_EVENT_O <= 1'b0;
            O_EVENT_OE_N <= 1'b1;
        end
        else
        begin
            if (sample_pulse)
                temp_reg <= temp_s;
            cond_prev <= shdn ? cond_prev : cond;
            // limits compare live, so a limit write acts at once
            if (!shdn && !cfg_reg[`TS_CFG_EVT_MODE])
                event_sts <= cond;
            else if (!shdn && cond && !cond_prev)
                event_sts <= 1'b1;
            else if (clear_pulse && cfg_reg[`TS_CFG_EVT_MODE])
                event_sts <= 1'b0;
            O_SDA_O <= 1'b0;
            O_SDA_OE_N <= sda_oe_n_reg;
            O_EVENT_O <= 1'b0;
            O_EVENT_OE_N <= ev_level;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    property p_timeout_release;
        timeout_hit |=> (state == ST_IDLE) && sda_oe_n_reg ##1 O_SDA_OE_N;
    endproperty
    a_timeout_release: assert property (p_timeout_release) else $error("timeout did not release sda");

    property p_count_in_txn;
        !in_txn |=> (to_cnt == 32'h0);
    endproperty
    a_count_in_txn: assert property (p_count_in_txn) else $error("timeout counted outside a transaction");

    property p_drive_on_fall;
        $changed(sda_oe_n_reg) |-> $past(drive_ok);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("sda changed away from scl fall");

    property p_idle_until_start;
        (state == ST_IDLE) && !evt.start |=> (state == ST_IDLE);
    endproperty
    a_idle_until_start: assert property (p_idle_until_start) else $error("left idle without start");

    property p_ack_low;
        (state == ST_ACK_OUT) |-> !sda_oe_n_reg;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack slot not driven low");

    property p_write_at_stop;
        $changed(upper_alarm_limit) || $changed(critical_limit) || $changed(cfg_reg)
            |-> $past(wr_go);
    endproperty
    a_write_at_stop: assert property (p_write_at_stop) else $error("register changed without stop");

    property p_ptr_after_reset;
        $fell(I_RST) |-> (ptr_reg == `TS_REG_CAP);
    endproperty
    a_ptr_after_reset: assert property (p_ptr_after_reset) else $error("pointer not at capability");

    property p_sample_store;
        sample_pulse |=> (temp_reg == $past(temp_s));
    endproperty
    a_sample_store: assert property (p_sample_store) else $error("sample not stored");

    property p_comparator_follow;
        !shdn && !cfg_reg[`TS_CFG_EVT_MODE] ##1 !$past(wr_cfg) |-> event_sts == $past(cond);
    endproperty
    a_comparator_follow: assert property (p_comparator_follow) else $error("comparator status wrong");

    property p_event_pin;
        ##1 O_EVENT_OE_N == ($past(evt_on) == $past(cfg_reg[`TS_CFG_EVT_POL]));
    endproperty
    a_event_pin: assert property (p_event_pin) else $error("event pin level wrong");

    c_write: cover property (wr_go);
    c_read_byte: cover property ((state == ST_TX) ##[1:300] (state == ST_ACK_IN));
    c_timeout: cover property (timeout_hit);
    c_event: cover property ($rose(event_sts));
endmodule

// ---- inc/ts_defs.svh ----
// Purpose: constants for the temperature sensor serial slave
// Assumes: 10 MHz system clock
// Notes: offsets are pointer values, not byte addresses
//
// Notes on behaviour
// - clock-low timeout resets interface, releases data
// - timeout lies between 25 and 35 ms
// - timeout counts only inside START..STOP
// - sample on clock rise, drive on fall, open-drain
// - power-on reset then conversion mode
// - data edge with clock high: START or STOP
// - ignore bus until START seen
// - address byte: 0011, straps, direction bit
// - acknowledge matching address and written bytes
// - master acks reads; NoACK then STOP ends
// - write: pointer plus two bytes, applied at STOP
// - read address sends pointed register at once
// - selective read via pointer then repeated START
// - eight 16-bit registers, pointer resets to capability
// - convert every 100 ms, hold result in shutdown
// - bus reads never disturb conversion timing
// - compare result with high, low, critical limits
// - event output mode and polarity configurable
// - writable registers reset zero, event disabled
// - limit writes raise event immediately when enabled
// - limits two's complement, LSB 0.25 degrees
// - result B12..B0 two's complement, B12 sign
// - result B15..B13 report limit relationships
`ifndef TS_DEFS_SVH
`define TS_DEFS_SVH

// ----------------------------------------
// register pointer values
// ----------------------------------------
`define TS_REG_CAP 3'h0
`define TS_REG_CFG 3'h1
`define TS_REG_UPPER 3'h2
`define TS_REG_LOWER 3'h3
`define TS_REG_CRIT 3'h4
`define TS_REG_TEMP 3'h5
`define TS_REG_MFR 3'h6
`define TS_REG_DEV 3'h7

// ----------------------------------------
// fields, masks and reset values
// ----------------------------------------
`define TS_CAP_VALUE 16'h0077
`define TS_RW_RESET 16'h0000
`define TS_CFG_WMASK 16'h07cf
`define TS_CFG_LOCKS 16'h00c0
`define TS_LIM_WMASK 16'h1ffc
`define TS_CFG_SHDN 8
`define TS_CFG_CRIT_LOCK 7
`define TS_CFG_ALARM_LOCK 6
`define TS_CFG_CLEAR 5
`define TS_CFG_EVT_STS 4
`define TS_CFG_EVT_EN 3
`define TS_CFG_CRIT_ONLY 2
`define TS_CFG_EVT_POL 1
`define TS_CFG_EVT_MODE 0
`define TS_ADDR_PREAMBLE 4'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define TS_CLK_HZ 10000000
`define TS_TIMEOUT_MS 25
`define TS_TIMEOUT_CYCLES ((`TS_TIMEOUT_MS * `TS_CLK_HZ) / 1000)
`define TS_CONV_MS 100
`define TS_CONV_CYCLES ((`TS_CONV_MS * `TS_CLK_HZ) / 1000)

`endif

// ---- inc/ts_pkg.sv ----
// Purpose: shared types of the temperature sensor slave
// Assumes: nothing
// Notes: constants live in ts_defs.svh
package ts_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_ACK_OUT, ST_TX, ST_ACK_IN} state_t;

    typedef struct packed {
        logic crit;
        logic high;
        logic low;
    } trip_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } bus_evt_t;
endpackage

// ---- logic/ts_sync.sv ----
// Purpose: two-stage synchroniser for pins
// Assumes: inputs asynchronous to i_clk
// Notes: only the second stage may be read
module ts_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= RST_VAL;
            o_q <= RST_VAL;
        end
        else
        begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule

// ---- logic/ts_conv_timer.sv ----
// Purpose: conversion cadence of the thermal sensor
// Assumes: i_run low during shutdown
// Notes: free of any bus input, so reads cannot shift it
`include "ts_defs.svh"
module ts_conv_timer #(
    parameter int CONV_CYCLES = `TS_CONV_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    output logic o_sample
);
    logic [31:0] cnt_reg;
    logic wrap;

    assign wrap = (cnt_reg == 32'(CONV_CYCLES - 1));

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_reg <= 32'h0;
            o_sample <= 1'b0;
        end
        else
        begin
            // restart after shutdown so the first sample is a full period away
            cnt_reg <= (!i_run || wrap) ? 32'h0 : cnt_reg + 32'h1;
            o_sample <= i_run && wrap;
        end
    end
endmodule

// ---- tb/ts_host.sv ----
// Purpose: bus master model for the sensor's serial port
// Assumes: tasks are entered at a falling edge of i_clk
// Notes: clock low 6 cycles, high 2, giving an 800 ns bus clock
module ts_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        o_scl = 1'b0;
        tick(1);
        o_sda = b;
        tick(5);
        o_scl = 1'b1;
        tick(2);
        r = i_sda;
        o_scl = 1'b0;
    endtask

    task automatic start();
        tick(1);
        o_sda = 1'b1;
        tick(5);
        o_scl = 1'b1;
        tick(3);
        o_sda = 1'b0;
        tick(3);
        o_scl = 1'b0;
    endtask

    // clock then stands high until the next frame
    task automatic stop();
        tick(1);
        o_sda = 1'b0;
        tick(5);
        o_scl = 1'b1;
        tick(3);
        o_sda = 1'b1;
        tick(3);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// ---- tb/ts_sensor_top_tb.sv ----
// Purpose: self-checking bench of the sensor's serial slave
// Assumes: short timeout and conversion counts
// Notes: only the sda wire is modelled with a pull-up; event is checked at ev_oe_n
module ts_sensor_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TO = 200;
    localparam int CV = 500;
    localparam logic [2:0] STRAP = 3'h5;
    logic clk = 1'b0;
    logic rst;
    logic [12:0] temp;
    logic scl;
    logic sda_m;
    logic sda_o;
    logic sda_oe_n;
    logic ev_oe_n;
    logic ev_o;
    logic [2:0] strap_pin = STRAP;
    wire logic sda = sda_m & (sda_oe_n | sda_o);
    int err_total = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    ts_sensor_top #(.TIMEOUT_CYCLES(TO), .CONV_CYCLES(CV)) u_dut (
        .I_SYS_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA_I(sda),
        .I_ADDR_STRAP(strap_pin), .I_SENSE_TEMP(temp), .O_SDA_O(sda_o),
        .O_SDA_OE_N(sda_oe_n), .O_EVENT_O(ev_o), .O_EVENT_OE_N(ev_oe_n));
    ts_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        u_host.wr_byte(d, a);
        chk({15'h0, a}, {15'h0, exp_ack});
    endtask

    task automatic wr_reg(input logic [2:0] p, input logic [15:0] d);
        u_host.start();
        send({4'h3, STRAP, 1'b0}, 1'b1);
        send({5'h0, p}, 1'b1);
        send(d[15:8], 1'b1);
        send(d[7:0], 1'b1);
        u_host.stop();
    endtask

    task automatic rd_reg(input logic [2:0] p, input logic [15:0] exp);
        logic [15:0] d;
        u_host.start();
        send({4'h3, STRAP, 1'b0}, 1'b1);
        send({5'h0, p}, 1'b1);
        u_host.start();
        send({4'h3, STRAP, 1'b1}, 1'b1);
        u_host.rd_byte(1'b1, d[15:8]);
        u_host.rd_byte(1'b0, d[7:0]);
        u_host.stop();
        chk(d, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_on();
        logic [15:0] d;
        chk({15'h0, sda_oe_n}, 16'h0001);
        chk({15'h0, ev_oe_n}, 16'h0001);
        chk({15'h0, ev_o}, 16'h0000);
        u_host.start();
        send({4'h3, STRAP, 1'b1}, 1'b1);
        u_host.rd_byte(1'b1, d[15:8]);
        u_host.rd_byte(1'b0, d[7:0]);
        u_host.stop();
        chk(d, 16'h0077);
        rd_reg(3'h1, 16'h0000);
    endtask

    task automatic t_refuse();
        logic a;
        u_host.wr_byte({4'h3, STRAP, 1'b1}, a);
        chk({15'h0, a}, 16'h0000);
        u_host.start();
        send({4'h3, 3'h2, 1'b1}, 1'b0);
        u_host.stop();
        strap_pin = 3'h2;
        u_host.start();
        send({4'h3, 3'h2, 1'b0}, 1'b1);
        u_host.stop();
        strap_pin = STRAP;
    endtask

    // ack held while the clock stays low, then dropped
    task automatic t_timeout();
        logic r;
        logic [7:0] a;
        a = {4'h3, STRAP, 1'b0};
        u_host.start();
        for (int i = 7; i >= 0; i--)
            u_host.bit_io(a[i], r);
        u_host.tick(TO - 20);
        chk({15'h0, sda_oe_n}, 16'h0000);
        u_host.tick(30);
        chk({15'h0, sda_oe_n}, 16'h0001);
        u_host.stop();
        rd_reg(3'h0, 16'h0077);
    endtask

    task automatic t_event();
        wr_reg(3'h4, 16'h0ff0);
        wr_reg(3'h2, 16'h0ff0);
        u_host.tick(CV + 50);
        wr_reg(3'h1, 16'h0008);
        u_host.tick(2);
        chk({15'h0, ev_oe_n}, 16'h0001);
        wr_reg(3'h2, 16'h0140);
        u_host.tick(2);
        chk({15'h0, ev_oe_n}, 16'h0000);
        rd_reg(3'h5, 16'h4190);
        wr_reg(3'h1, 16'h000a);
        u_host.tick(2);
        chk({15'h0, ev_oe_n}, 16'h0001);
        temp = 13'h1f00;
        u_host.tick(CV + 50);
        rd_reg(3'h5, 16'h3f00);
        wr_reg(3'h1, 16'h0100);
        temp = 13'h0190;
        u_host.tick(CV + 50);
        rd_reg(3'h5, 16'h3f00);
    endtask

    // interrupt mode, critical-only selection, then a mid-run power-on reset
    task automatic t_irq();
        wr_reg(3'h1, 16'h0009);
        u_host.tick(2);
        chk({15'h0, ev_oe_n}, 16'h0000);
        wr_reg(3'h1, 16'h0029);
        u_host.tick(2);
        chk({15'h0, ev_oe_n}, 16'h0001);
        rd_reg(3'h1, 16'h0009);
        wr_reg(3'h2, 16'h0ff0);
        wr_reg(3'h2, 16'h0140);
        u_host.tick(2);
        chk({15'h0, ev_oe_n}, 16'h0000);
        wr_reg(3'h1, 16'h000c);
        u_host.tick(2);
        chk({15'h0, ev_oe_n}, 16'h0001);
        rst = 1'b1;
        u_host.tick(2);
        rst = 1'b0;
        u_host.tick(3);
        chk({15'h0, ev_o}, 16'h0000);
        rd_reg(3'h2, 16'h0000);
    endtask

    task test_done();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        temp = 13'h0190;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        u_host.tick(3);
        t_power_on();
        t_refuse();
        t_timeout();
        t_event();
        t_irq();
        test_done();
    end

    // whole run needs about one millisecond
    initial
    begin
        #5000000;
        err_total++;
        test_done();
    end
endmodule
